/* File: common/scss_pkg.sv */
// constants and types shared by the system clock source select block
package scss_pkg;
    // ---------------------------------------------------------------
    // register byte offsets on the AXI4-Lite slave
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h00;
    localparam logic [7:0] ADDR_HF_TRIM = 8'h04;
    localparam logic [7:0] ADDR_LF_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_T3_CONTROL = 8'h0C;
    localparam logic [7:0] ADDR_T3_COUNT = 8'h10;
    localparam logic [7:0] ADDR_T3_RELOAD = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int SEL_LSB = 0;      // source_select_field [1:0]
    localparam int DIV_LSB = 4;      // post_divider_field [6:4]
    localparam int LFD_LSB = 0;      // lf_osc_divider_field [1:0]
    localparam int LFT_LSB = 2;      // lf_osc_coarse_trim_field [5:2]
    localparam int LFEN_BIT = 7;     // lf oscillator enable
    localparam int T3RUN_BIT = 0;    // timer 3 run
    localparam int T3CAP_BIT = 1;    // timer 3 lf capture mode

    // ---------------------------------------------------------------
    // source select codes and reset values
    // ---------------------------------------------------------------
    localparam logic [1:0] SEL_HF = 2'h0;
    localparam logic [1:0] SEL_EXT = 2'h1;
    localparam logic [1:0] SEL_LF = 2'h2;
    localparam logic [1:0] SEL_RESET = 2'h0;
    localparam logic [2:0] DIV_RESET = 3'h3;          // divide by 8
    localparam logic [1:0] LFD_RESET = 2'h0;
    localparam logic [3:0] LFT_RESET = 4'h8;

    // ---------------------------------------------------------------
    // oscillator models: phase accumulators clocked by clk_sys
    // ---------------------------------------------------------------
    localparam real CLK_SYS_MHZ = 100.0;
    localparam real HF_NOMINAL_MHZ = 24.5;
    localparam real LF_NOMINAL_KHZ = 80.0;
    localparam int HF_ACC_W = 12;
    localparam int LF_ACC_W = 20;
    // increment = f_osc / f_sys * 2^W, rounded
    localparam logic [11:0] HF_TRIM_RESET =
        12'(int'(HF_NOMINAL_MHZ / CLK_SYS_MHZ * 4096.0));
    localparam logic [19:0] LF_INC_BASE = 20'h00307;
    localparam logic [19:0] LF_INC_STEP = 20'h00008;

    // active source, one-hot
    typedef enum logic [2:0] {
        SRC_HF = 3'b001,
        SRC_EXT = 3'b010,
        SRC_LF = 3'b100
    } scss_src_t;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/scss_clock_select.sv */
// system clock source select, post-divider, lf calibration capture
//
// Contract
// - Offer high-frequency, low-frequency oscillator and external pin sources.
// - Post-divide the selected source by a power of two, 1 to 128.
// - Reset selects the high-frequency oscillator divided by eight.
// - High-frequency oscillator turns on whenever it is requested.
// - Trim register sets its frequency, preloaded to the nominal value.
// - Low-frequency output divider selects divide by 1, 2, 4 or 8.
// - Coarse trim field adjusts the low-frequency oscillator frequency.
// - Timer 3 capture mode copies count into reload on lf edges.
// - External pin also clocks peripherals while running internal oscillators.
// - External input is resynchronised to the system clock for peripherals.
// - Only select code 01 chooses the external pin as source.
// - Sources switch on the fly; firmware picks only settled sources.
// - Post-divider setting may be changed at any time.
// - Internal oscillators usable right after the enabling write.
`timescale 1ns/1ps
`default_nettype none
module scss_clock_select (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // external clock pin
    input wire logic ext_clk_pin,
    // clock enables and oscillator status
    output logic sys_clk_en,
    output logic periph_ext_clk_en,
    output logic hf_osc_on,
    output logic lf_osc_on,
    // axi4-lite write address
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    // axi4-lite write response
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    // axi4-lite read data
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sel;
        logic [2:0] div;
        logic [11:0] hf_trim;
        logic [1:0] lf_div;
        logic [3:0] lf_trim;
        logic lf_en;
        logic t3_run;
        logic t3_lfcap;
        logic [15:0] t3_count;
        logic [15:0] t3_reload;
        scss_pkg::scss_src_t active;
        logic [2:0] lf_cnt;
        logic lf_prev;
        logic lf_out_prev;
        logic sys_prev;
        logic [6:0] post_cnt;
        logic [2:0] cur_div;
        logic sys_clk_en;
        logic periph_ext_en;
        logic hf_on;
        logic lf_on;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } scss_top_state_t;

    scss_top_state_t st;
    scss_top_state_t next_st;

    logic hf_level;
    logic lf_level;
    logic ext_level;
    logic ext_rise;
    logic [19:0] lf_inc;
    scss_pkg::scss_src_t req_src;
    logic lf_out_level;
    logic lf_out_rise;
    logic cur_level;
    logic new_level;
    logic pend;
    logic cutover;
    logic sel_rise;
    logic do_write;
    logic [31:0] wmask;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [6:0] div_mask(input logic [2:0] d);
        logic [7:0] m;
        m = (8'h01 << d) - 8'h01;
        return m[6:0];
    endfunction

    function automatic logic src_level(input scss_pkg::scss_src_t s,
                                       input logic hf, input logic ext,
                                       input logic lf);
        logic l;
        l = 1'b0;
        case (s)
            scss_pkg::SRC_HF: l = hf;
            scss_pkg::SRC_EXT: l = ext;
            scss_pkg::SRC_LF: l = lf;
            default: l = 1'b0;
        endcase
        return l;
    endfunction

    // ---------------------------------------------------------------
    // sources
    // ---------------------------------------------------------------
    // coarse trim steps the lf increment around the nominal rate
    assign lf_inc = 20'(scss_pkg::LF_INC_BASE +
                        scss_pkg::LF_INC_STEP * {16'h0000, st.lf_trim});

    // the trim register is the hf increment, i.e. its frequency
    scss_phase_osc #(.WIDTH(scss_pkg::HF_ACC_W)) u_hf_osc (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .enable(st.hf_on),
        .increment(st.hf_trim),
        .level(hf_level)
    );

    scss_phase_osc #(.WIDTH(scss_pkg::LF_ACC_W)) u_lf_osc (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .enable(st.lf_on),
        .increment(lf_inc),
        .level(lf_level)
    );

    scss_ext_sync u_ext_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .pin(ext_clk_pin),
        .level(ext_level),
        .rise(ext_rise)
    );

    // ---------------------------------------------------------------
    // source decode, lf output divider, glitch-free cutover
    // ---------------------------------------------------------------
    always_comb begin
        // only code 01 reaches the pin; the spare code falls back to hf
        case (st.sel)
            scss_pkg::SEL_EXT: req_src = scss_pkg::SRC_EXT;
            scss_pkg::SEL_LF: req_src = scss_pkg::SRC_LF;
            default: req_src = scss_pkg::SRC_HF;
        endcase
        case (st.lf_div)
            2'h0: lf_out_level = lf_level;
            2'h1: lf_out_level = st.lf_cnt[0];
            2'h2: lf_out_level = st.lf_cnt[1];
            default: lf_out_level = st.lf_cnt[2];
        endcase
        lf_out_rise = lf_out_level & ~st.lf_out_prev;
        cur_level = src_level(st.active, hf_level, ext_level, lf_out_level);
        new_level = src_level(req_src, hf_level, ext_level, lf_out_level);
        pend = (req_src != st.active);
        // a source stuck high never lets the switch complete
        cutover = pend && !cur_level && !new_level;
        sel_rise = !cutover && cur_level && !st.sys_prev;
        do_write = st.aw_got && st.w_got && !st.bvalid;
        wmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}},
                 {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        logic [31:0] old;
        logic [31:0] nw;
        logic hit;
        old = 32'h0000_0000;
        nw = 32'h0000_0000;
        hit = 1'b0;
        next_st = st;

        // oscillator enables: hf follows any request with no extra step
        next_st.hf_on = (st.active == scss_pkg::SRC_HF) ||
                        (req_src == scss_pkg::SRC_HF);
        next_st.lf_on = st.lf_en || (st.active == scss_pkg::SRC_LF) ||
                        (req_src == scss_pkg::SRC_LF);

        // lf divider chain counts raw lf rising edges
        next_st.lf_prev = lf_level;
        next_st.lf_out_prev = lf_out_level;
        if (lf_level && !st.lf_prev) begin
            next_st.lf_cnt = st.lf_cnt + 3'h1;
        end

        // source switch and selected-clock edge detection
        if (cutover) begin
            next_st.active = req_src;
            next_st.sys_prev = 1'b0;
        end else begin
            next_st.sys_prev = cur_level;
        end

        // post-divider; a new ratio is taken at the next output pulse
        next_st.sys_clk_en = 1'b0;
        if (sel_rise) begin
            if ((st.post_cnt & div_mask(st.cur_div)) ==
                div_mask(st.cur_div)) begin
                next_st.sys_clk_en = 1'b1;
                next_st.post_cnt = 7'h00;
                next_st.cur_div = st.div;
            end else begin
                next_st.post_cnt = st.post_cnt + 7'h01;
            end
        end

        // resynchronised pin edges for the peripheral clocks
        next_st.periph_ext_en = ext_rise;

        // timer 3 counts clk_sys as the known time base
        if (st.t3_run) begin
            if (!st.t3_lfcap && st.t3_count == 16'hFFFF) begin
                next_st.t3_count = st.t3_reload;
            end else begin
                next_st.t3_count = st.t3_count + 16'h0001;
            end
        end

        // axi write channels, accepted independently
        if (s_axil_awvalid && st.awready) begin
            next_st.awready = 1'b0;
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axil_awaddr;
        end
        if (s_axil_wvalid && st.wready) begin
            next_st.wready = 1'b0;
            next_st.w_got = 1'b1;
            next_st.wdata = s_axil_wdata;
            next_st.wstrb = s_axil_wstrb;
        end
        if (do_write) begin
            hit = 1'b1;
            case (st.awaddr)
                scss_pkg::ADDR_CLOCK_SELECT:
                    old = {25'h0, st.div, 2'h0, st.sel};
                scss_pkg::ADDR_HF_TRIM: old = {20'h0, st.hf_trim};
                scss_pkg::ADDR_LF_CONTROL:
                    old = {24'h0, st.lf_en, 1'b0, st.lf_trim, st.lf_div};
                scss_pkg::ADDR_T3_CONTROL:
                    old = {30'h0, st.t3_lfcap, st.t3_run};
                scss_pkg::ADDR_T3_COUNT: old = {16'h0, st.t3_count};
                scss_pkg::ADDR_T3_RELOAD: old = {16'h0, st.t3_reload};
                default: hit = 1'b0;
            endcase
            nw = (old & ~wmask) | (st.wdata & wmask);
            case (st.awaddr)
                scss_pkg::ADDR_CLOCK_SELECT: begin
                    next_st.sel = nw[scss_pkg::SEL_LSB +: 2];
                    next_st.div = nw[scss_pkg::DIV_LSB +: 3];
                end
                scss_pkg::ADDR_HF_TRIM: next_st.hf_trim = nw[11:0];
                scss_pkg::ADDR_LF_CONTROL: begin
                    next_st.lf_div = nw[scss_pkg::LFD_LSB +: 2];
                    next_st.lf_trim = nw[scss_pkg::LFT_LSB +: 4];
                    next_st.lf_en = nw[scss_pkg::LFEN_BIT];
                end
                scss_pkg::ADDR_T3_CONTROL: begin
                    next_st.t3_run = nw[scss_pkg::T3RUN_BIT];
                    next_st.t3_lfcap = nw[scss_pkg::T3CAP_BIT];
                end
                scss_pkg::ADDR_T3_COUNT: next_st.t3_count = nw[15:0];
                scss_pkg::ADDR_T3_RELOAD: next_st.t3_reload = nw[15:0];
                default: next_st.bresp = scss_pkg::RESP_SLVERR;
            endcase
            next_st.bresp = hit ? scss_pkg::RESP_OKAY : scss_pkg::RESP_SLVERR;
            next_st.bvalid = 1'b1;
        end
        if (st.bvalid && s_axil_bready) begin
            next_st.bvalid = 1'b0;
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end

        // lf capture beats a same-cycle software write of the reload
        if (st.t3_lfcap && lf_out_rise) begin
            next_st.t3_reload = st.t3_count;
        end

        // axi read: answer the cycle after the address is taken
        if (s_axil_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = scss_pkg::RESP_OKAY;
            case (s_axil_araddr)
                scss_pkg::ADDR_CLOCK_SELECT:
                    next_st.rdata = {25'h0, st.div, 2'h0, st.sel};
                scss_pkg::ADDR_HF_TRIM: next_st.rdata = {20'h0, st.hf_trim};
                scss_pkg::ADDR_LF_CONTROL: next_st.rdata =
                    {24'h0, st.lf_en, 1'b0, st.lf_trim, st.lf_div};
                scss_pkg::ADDR_T3_CONTROL:
                    next_st.rdata = {30'h0, st.t3_lfcap, st.t3_run};
                scss_pkg::ADDR_T3_COUNT: next_st.rdata = {16'h0, st.t3_count};
                scss_pkg::ADDR_T3_RELOAD:
                    next_st.rdata = {16'h0, st.t3_reload};
                scss_pkg::ADDR_STATUS: next_st.rdata =
                    {26'h0, st.lf_on, st.hf_on, pend, st.active};
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = scss_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st.rvalid && s_axil_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st <= '0;
            st.sel <= scss_pkg::SEL_RESET;
            st.div <= scss_pkg::DIV_RESET;
            st.cur_div <= scss_pkg::DIV_RESET;
            st.active <= scss_pkg::SRC_HF;
            st.hf_trim <= scss_pkg::HF_TRIM_RESET;
            st.lf_div <= scss_pkg::LFD_RESET;
            st.lf_trim <= scss_pkg::LFT_RESET;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs, all from the state register
    assign sys_clk_en = st.sys_clk_en;
    assign periph_ext_clk_en = st.periph_ext_en;
    assign hf_osc_on = st.hf_on;
    assign lf_osc_on = st.lf_on;
    assign s_axil_awready = st.awready;
    assign s_axil_wready = st.wready;
    assign s_axil_bresp = st.bresp;
    assign s_axil_bvalid = st.bvalid;
    assign s_axil_arready = st.arready;
    assign s_axil_rdata = st.rdata;
    assign s_axil_rresp = st.rresp;
    assign s_axil_rvalid = st.rvalid;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_reset_hf_div8: assert property ($rose(reset_n) |->
        st.active == scss_pkg::SRC_HF && st.cur_div == 3'h3 &&
        st.hf_trim == scss_pkg::HF_TRIM_RESET)
        else $error("reset did not select hf divided by eight");
    a_ext_only_01: assert property ((st.active == scss_pkg::SRC_EXT &&
        !pend) |-> st.sel == 2'h1)
        else $error("external source active without code 01");
    a_hf_auto_on: assert property ((req_src == scss_pkg::SRC_HF) |=>
        hf_osc_on)
        else $error("hf oscillator not enabled when requested");
    a_switch_low: assert property ($changed(st.active) |->
        !$past(cur_level) && !$past(new_level) &&
        st.active == $past(req_src))
        else $error("source switched while a clock was high");
    a_post_div: assert property ((sel_rise && (st.post_cnt &
        div_mask(st.cur_div)) == div_mask(st.cur_div)) |=> sys_clk_en)
        else $error("post-divider missed its output pulse");
    a_en_needs_edge: assert property (sys_clk_en |-> $past(sel_rise))
        else $error("clock enable without selected-source edge");
    a_div_any_time: assert property ((do_write &&
        st.awaddr == scss_pkg::ADDR_CLOCK_SELECT && st.wstrb[0]) |=>
        st.div == $past(st.wdata[6:4]))
        else $error("post-divider write not accepted");
    a_lf_capture: assert property ((st.t3_lfcap && lf_out_rise) |=>
        st.t3_reload == $past(st.t3_count))
        else $error("lf edge did not capture timer count");
    a_ext_resync: assert property (periph_ext_clk_en |->
        $past(ext_rise) && !$past(periph_ext_clk_en))
        else $error("peripheral clock not from resynchronised edge");
    a_lf_no_wait: assert property ((do_write &&
        st.awaddr == scss_pkg::ADDR_LF_CONTROL && st.wstrb[0] &&
        st.wdata[7]) |-> ##[1:2] lf_osc_on)
        else $error("lf oscillator not running after enable");

    c_to_lf: cover property ($changed(st.active) &&
        st.active == scss_pkg::SRC_LF);
    c_to_ext: cover property ($changed(st.active) &&
        st.active == scss_pkg::SRC_EXT);
    c_div1: cover property (sys_clk_en && st.cur_div == 3'h0);
    c_capture: cover property (st.t3_lfcap && lf_out_rise);
endmodule
`default_nettype wire

/* File: rtl/scss_ext_sync.sv */
// two-flop resynchroniser for the external clock pin with edge pulse
`timescale 1ns/1ps
`default_nettype none
module scss_ext_sync (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // raw pin
    input wire logic pin,
    // synchronised outputs
    output logic level,
    output logic rise
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic rise;
    } scss_sync_state_t;

    scss_sync_state_t st;
    scss_sync_state_t next_st;

    // meta feeds only sync; the edge is taken from sync and prev
    always_comb begin
        next_st = st;
        next_st.meta = pin;
        next_st.sync = st.meta;
        next_st.prev = st.sync;
        next_st.rise = st.sync & ~st.prev;
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.prev;
    assign rise = st.rise;
endmodule
`default_nettype wire

/* File: rtl/scss_phase_osc.sv */
// phase-accumulator model of an internal oscillator, square level out
`timescale 1ns/1ps
`default_nettype none
module scss_phase_osc #(
    parameter int WIDTH = 12
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // control
    input wire logic enable,
    input wire logic [WIDTH-1:0] increment,
    // oscillator output level
    output logic level
);
    typedef struct packed {
        logic [WIDTH-1:0] acc;
    } scss_osc_state_t;

    scss_osc_state_t st;
    scss_osc_state_t next_st;

    // free running while enabled; parked low so a mux sees a clean low
    always_comb begin
        next_st = st;
        if (enable) begin
            next_st.acc = st.acc + increment;
        end else begin
            next_st.acc = '0;
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.acc[WIDTH-1];
endmodule
`default_nettype wire

/* File: test/test_system_clock_source_select.sv */
// self-checking bench for the system clock source select block
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_source_select;
    logic clk_sys = 0, reset_n = 0, ext_clk_pin = 0, ext_run = 0;
    logic sys_clk_en, periph_ext_clk_en, hf_osc_on, lf_osc_on;
    logic [7:0] s_axil_awaddr = 0, s_axil_araddr = 0;
    logic [31:0] s_axil_wdata = 0, s_axil_rdata, d;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
    logic s_axil_arvalid = 0, s_axil_rready = 0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready;
    logic s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp, r;
    logic [2:0] ph = 0;
    int error_cnt = 0, samples_checked = 0, c[3], k;
    scss_clock_select dut_u (
        .clk_sys(clk_sys), .reset_n(reset_n), .ext_clk_pin(ext_clk_pin),
        .sys_clk_en(sys_clk_en), .periph_ext_clk_en(periph_ext_clk_en),
        .hf_osc_on(hf_osc_on), .lf_osc_on(lf_osc_on),
        .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready)
    );
    // free clock; the pin toggles only while ext_run, period 8 cycles
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (ext_run) begin
        ph <= ph + 3'h1;
        if (ph[1:0] == 2'h3) ext_clk_pin <= ~ext_clk_pin;
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // write: both channels offered together, bready held until bvalid
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        s_axil_awaddr <= a; s_axil_wdata <= v; s_axil_bready <= 1;
        s_axil_awvalid <= 1; s_axil_wvalid <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 0;
            if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 0;
        end while (s_axil_bvalid !== 1);
        r = s_axil_bresp; s_axil_bready <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axil_araddr <= a; s_axil_arvalid <= 1; s_axil_rready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 0;
        end while (s_axil_rvalid !== 1);
        d = s_axil_rdata; r = s_axil_rresp; s_axil_rready <= 0;
    endtask
    // count enable pulses over n cycles
    task cnt(input int n, output int o, input logic p);
        o = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if ((p ? periph_ext_clk_en : sys_clk_en) === 1) o++;
        end
    endtask
    // select a source, then poll status until the switch settles
    task sw(input logic [31:0] v, input logic [2:0] e);
        wr(8'h00, v);
        for (k = 0; k < 40; k++) begin
            rd(8'h18);
            if (d[3] === 0) break;
            repeat (100) @(posedge clk_sys);
        end
        chk("active source", d[2:0], e);
    endtask
    task t_reset;
        rd(8'h00); chk("clock select", d, 32'h30);
        rd(8'h04); chk("hf trim", d, {20'h0, scss_pkg::HF_TRIM_RESET});
        rd(8'h08); chk("lf control", d, 32'h20);
        rd(8'h18); chk("status", d[4:0], 5'h11);
        chk("hf on", hf_osc_on, 1);
        rd(8'h1C); chk("unmapped read", r, 2'h2);
        wr(8'h18, 32'h4); chk("status write", r, 2'h2);
    endtask
    task t_div;
        for (int n = 0; n < 3; n++) begin
            wr(8'h00, 32'(n) << 4);
            cnt(300, c[n], 0);
            cnt(2048, c[n], 0);
        end
        for (int n = 0; n < 2; n++)
            chk("ratio", c[n] > 2 * c[n+1] - 4 && c[n] < 2 * c[n+1] + 4, 1);
    endtask
    task t_ext;
        ext_run <= 1;
        cnt(800, c[0], 1);
        chk("periph pulses", c[0] >= 99 && c[0] <= 101, 1);
        sw(32'h01, 3'b010);
        // the old ratio runs out first; the new one starts at the next pulse
        cnt(100, c[0], 0);
        cnt(800, c[0], 0);
        chk("ext sys pulses", c[0] >= 99 && c[0] <= 101, 1);
        sw(32'h03, 3'b001);
    endtask
    task t_lf;
        wr(8'h08, 32'hA0);
        sw(32'h02, 3'b100);
        chk("lf on", lf_osc_on, 1);
        wr(8'h0C, 32'h3);
        repeat (3000) @(posedge clk_sys);
        rd(8'h14); chk("capture", d !== 32'h0, 1);
        // lf output divided by two: one pulse per 2500 cycles or so
        wr(8'h08, 32'hA1);
        cnt(10000, c[0], 0);
        chk("lf div2 pulses", c[0] >= 3 && c[0] <= 5, 1);
        sw(32'h00, 3'b001);
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog sized well past the roughly 25k cycles the tests need
    initial begin
        #500000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1;
        @(posedge clk_sys);
        t_reset; t_div; t_ext; t_lf;
        wrap_up;
    end
endmodule
`default_nettype wire
